// ### uart_irq_pkg.sv
/*
 * Shared constants and carriers for the UART interrupt prioritiser:
 * register offsets, field positions, reset values, source codes.
 * Assumes a 32-bit APB host and a UART datapath on the same clock.
 */
package uart_irq_pkg;

   // -------------------------------------------------------------
   // register offsets (byte addresses, one aligned word each)
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA  = 8'h00; // receive/transmit holding
   localparam logic [7:0] ADDR_IEN   = 8'h04; // interrupt_enable
   localparam logic [7:0] ADDR_ISTAT = 8'h08; // rd status, wr fifo_control
   localparam logic [7:0] ADDR_ENH   = 8'h0c; // enhanced_function
   localparam logic [7:0] ADDR_LSTAT = 8'h14; // line_status
   localparam logic [7:0] ADDR_MSTAT = 8'h18; // modem_status
   localparam logic [7:0] ADDR_GP    = 8'h2c; // gp_pin_level

   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int ENH_ENABLE_BIT  = 4;
   localparam int ENH_AUTORTS_BIT = 6;
   localparam int ENH_AUTOCTS_BIT = 7;
   localparam int FCTL_FIFO_BIT   = 0;
   localparam logic [7:0] IEN_RESET = 8'h00;
   localparam logic [7:0] ENH_RESET = 8'h00;
   localparam logic [3:0] IEN_ENH_MASK = 4'hf; // bits 7:4 need enhance

   // -------------------------------------------------------------
   // interrupt source codes, status bits 5:0
   // -------------------------------------------------------------
   localparam logic [5:0] CODE_LINE  = 6'h06;
   localparam logic [5:0] CODE_TOUT  = 6'h0c;
   localparam logic [5:0] CODE_RECEIVE_READY_EVENT = 6'h04;
   localparam logic [5:0] CODE_TRANSMIT_READY_EVENT = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_GPIO  = 6'h30;
   localparam logic [5:0] CODE_XOFF  = 6'h10;
   localparam logic [5:0] CODE_FLOW  = 6'h20;
   localparam logic [5:0] CODE_NONE  = 6'h01;

   // receive timeout: four characters plus twelve bit times
   localparam logic [6:0] TOUT_CHARS = 7'h04;
   localparam logic [6:0] TOUT_BITS  = 7'h0c;

   // -------------------------------------------------------------
   // carriers from the UART datapath
   // -------------------------------------------------------------
   typedef struct packed {
      logic [6:0] level;    // characters in receive FIFO
      logic [6:0] trig;     // programmed receive trigger level
      logic [2:0] head_err; // break, framing, parity of head char
      logic       any_err;  // some errored character in FIFO
      logic       push;     // pulse: character entered FIFO
      logic       overrun;  // pulse: overrun on reception
      logic [7:0] data;     // head character
   } rx_stat_t;

   typedef struct packed {
      logic [6:0] spaces;    // free transmit FIFO spaces
      logic [6:0] trig;      // programmed transmit trigger level
      logic       hold_empty; // holding register / FIFO empty
      logic       all_empty;  // FIFO and shifter empty
   } tx_stat_t;

endpackage

// ### uart_irq_core.sv
/*
 * Interrupt enable, prioritisation and clearing of a FIFO UART,
 * plus the line status flags used when polling, behind an APB slave.
 * Assumes the receiver/transmitter datapath runs on SYS_CLK and
 * reports through rx_stat_t/tx_stat_t; pins CTS_N and GP_IN are
 * asynchronous and are synchronised here.
 */
// How it works
// - FIFO receive interrupt follows trigger level
// - data-ready flag set on push, cleared empty
// - enables 0-3 clear means polled mode; GP toggle has no enable and still interrupts
// - line status bits report errors, empties
// - enable 0 gates receive data interrupt
// - enable 1 gates transmit ready, immediate too
// - enable 2 gates line status interrupt
// - overrun raises line interrupt at once
// - enable 3 modem interrupt, cleared reading modem
// - bits 4-7 need enhance; bit 4 sleeps
// - Xoff/special sets status bit 4
// - RTS rising edge interrupt under auto RTS
// - CTS rising edge interrupt, modem read clears
// - timeout after four chars plus twelve bits
// - transmit ready clears on status read, write
// - GP input toggle interrupt, cleared by read
// - line interrupt holds while errored chars remain
// - status read shows highest pending source only
// - codes for levels one to four
// - codes for levels five to eight, none
// - status bit 0 low when pending
// - status bits 7:6 mirror FIFO enable
// - status bit 5 only with enhance; GP code 0x30 sets it without enhance
`timescale 1ns/1ps

module uart_irq_core (
   input  wire logic                   SYS_CLK,
   input  wire logic                   RST,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   output      logic [31:0]            PRDATA,
   output      logic                   PREADY,
   output      logic                   PSLVERR,
   input  wire uart_irq_pkg::rx_stat_t RX_STAT,
   input  wire uart_irq_pkg::tx_stat_t TX_STAT,
   input  wire logic                   BIT_TICK,
   input  wire logic [3:0]             CHAR_BITS,
   input  wire logic [3:0]             MODEM_DELTA,
   input  wire logic                   XOFF_MATCH,
   input  wire logic                   XON_MATCH,
   input  wire logic                   SPECIAL_MATCH,
   input  wire logic                   RTS_LEVEL,
   input  wire logic                   CTS_N,
   input  wire logic [3:0]             GP_IN,
   output      logic                   RX_POP,
   output      logic                   TX_WSTB,
   output      logic [7:0]             TX_WDATA,
   output      logic                   FIFO_ON,
   output      logic                   SLEEP_EN,
   output      logic                   IRQ_N
);
   import uart_irq_pkg::*;

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_SETUP = 2'b01,
      ACC_DONE  = 2'b10
   } acc_t;

   acc_t        acc_reg;
   acc_t        acc_next;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic        setup_w;
   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] o);
      hit = (a == o);
   endfunction

   // slave always ready: every access completes in its first cycle
   assign setup_w = PSEL & ~PENABLE;
   assign wr_acc  = PSEL & PENABLE & PWRITE;
   assign rd_acc  = PSEL & PENABLE & ~PWRITE;
   assign mapped  = hit(PADDR, ADDR_DATA)  | hit(PADDR, ADDR_IEN) |
                    hit(PADDR, ADDR_ISTAT) | hit(PADDR, ADDR_ENH) |
                    hit(PADDR, ADDR_LSTAT) | hit(PADDR, ADDR_MSTAT) |
                    hit(PADDR, ADDR_GP);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA  = prdata_reg;

   wire wr_ien  = wr_acc & hit(PADDR, ADDR_IEN);
   wire wr_fctl = wr_acc & hit(PADDR, ADDR_ISTAT);
   wire wr_enh  = wr_acc & hit(PADDR, ADDR_ENH);
   wire wr_thr  = wr_acc & hit(PADDR, ADDR_DATA);
   wire rd_rhr  = rd_acc & hit(PADDR, ADDR_DATA);
   wire rd_isr  = rd_acc & hit(PADDR, ADDR_ISTAT);
   wire rd_lsr  = rd_acc & hit(PADDR, ADDR_LSTAT);
   wire rd_msr  = rd_acc & hit(PADDR, ADDR_MSTAT);
   wire rd_gp   = rd_acc & hit(PADDR, ADDR_GP);

   // tracks the phase only so that a stray access phase is visible
   always_comb begin
      case (acc_reg)
         ACC_IDLE:  acc_next = setup_w ? ACC_SETUP : ACC_IDLE;
         ACC_SETUP: acc_next = ACC_DONE;
         ACC_DONE:  acc_next = setup_w ? ACC_SETUP : ACC_IDLE;
         default:   acc_next = ACC_IDLE;
      endcase
   end

   // -------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------
   logic [7:0] ien_reg;
   logic [7:0] enh_reg;
   logic       fifo_reg;
   logic [7:0] txd_reg;
   logic       txs_reg;
   logic       pop_reg;
   logic       enh_on;
   logic [7:0] ien_eff;

   // upper enables only count while enhanced functions are on
   assign enh_on  = enh_reg[ENH_ENABLE_BIT];
   assign ien_eff = {ien_reg[7:4] & {4{enh_on}}, ien_reg[3:0]};

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         acc_reg  <= ACC_IDLE;
         ien_reg  <= IEN_RESET;
         enh_reg  <= ENH_RESET;
         fifo_reg <= 1'b0;
         txd_reg  <= 8'h00;
         txs_reg  <= 1'b0;
         pop_reg  <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         if (wr_ien)
            ien_reg <= PWDATA[7:0];
         if (wr_enh)
            enh_reg <= PWDATA[7:0];
         if (wr_fctl)
            fifo_reg <= PWDATA[FCTL_FIFO_BIT];
         if (wr_thr)
            txd_reg <= PWDATA[7:0];
         txs_reg  <= wr_thr;
         pop_reg  <= rd_rhr;
      end
   end

   assign TX_WDATA = txd_reg;
   assign TX_WSTB  = txs_reg;
   assign RX_POP   = pop_reg;
   assign FIFO_ON  = fifo_reg;
   assign SLEEP_EN = ien_eff[4];

   // -------------------------------------------------------------
   // pin synchronisers: three flops, change taken when 2nd = 3rd
   // -------------------------------------------------------------
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic [4:0] s3_reg;
   logic [4:0] pin_reg;
   logic [4:0] pin_next;

   assign pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         s1_reg  <= 5'h00;
         s2_reg  <= 5'h00;
         s3_reg  <= 5'h00;
         pin_reg <= 5'h00;
      end else begin
         s1_reg  <= {CTS_N, GP_IN};
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= pin_next;
      end
   end

   wire       cts_rise = pin_next[4] & ~pin_reg[4];
   wire [3:0] gp_tog   = pin_next[3:0] ^ pin_reg[3:0];

   // -------------------------------------------------------------
   // line status flags
   // -------------------------------------------------------------
   logic       dr_reg;
   logic       ovr_reg;
   logic [7:0] line_status;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dr_reg  <= 1'b0;
         ovr_reg <= 1'b0;
      end else begin
         // push wins over the empty test in the same cycle
         dr_reg  <= RX_STAT.push | (dr_reg & (RX_STAT.level != 7'h00));
         ovr_reg <= RX_STAT.overrun | (ovr_reg & ~rd_lsr);
      end
   end

   assign line_status = {RX_STAT.any_err, TX_STAT.all_empty,
                 TX_STAT.hold_empty, RX_STAT.head_err, ovr_reg, dr_reg};

   // -------------------------------------------------------------
   // receive timeout timer, counted in bit times
   // -------------------------------------------------------------
   logic [6:0] tmr_reg;
   logic [6:0] tmr_lim;
   logic       tout_reg;
   wire        tmr_hit = (tmr_reg == tmr_lim);

   assign tmr_lim = TOUT_CHARS * {3'h0, CHAR_BITS} + TOUT_BITS;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tmr_reg  <= 7'h00;
         tout_reg <= 1'b0;
      end else begin
         if (RX_STAT.push | rd_rhr | ~dr_reg)
            tmr_reg <= 7'h00;
         else if (BIT_TICK & ~tmr_hit)
            tmr_reg <= tmr_reg + 7'h01;
         // a read of the holding register clears the timeout
         tout_reg <= (tmr_hit & dr_reg & ~rd_rhr) | (tout_reg & ~rd_rhr);
      end
   end

   // -------------------------------------------------------------
   // sticky event sources; a set beats a clear in the same cycle
   // -------------------------------------------------------------
   logic       tx_cond;
   logic       tx_cond_reg;
   logic       thr_reg;
   logic [3:0] mdl_reg;
   logic       flow_reg;
   logic       gpi_reg;
   logic       xoff_reg;
   logic       spc_reg;
   logic       rts_reg;
   wire        rts_rise = RTS_LEVEL & ~rts_reg;
   wire        ien1_on  = wr_ien & PWDATA[1] & ~ien_reg[1];
   wire        thr_set;
   wire        flow_set;

   // FIFO mode: spaces above trigger; else holding register empty
   assign tx_cond  = fifo_reg ? (TX_STAT.spaces > TX_STAT.trig)
                              : TX_STAT.hold_empty;
   assign thr_set  = (tx_cond & ~tx_cond_reg) | (ien1_on & tx_cond);
   assign flow_set =
      (ien_eff[6] & enh_reg[ENH_AUTORTS_BIT] & rts_rise) |
      (ien_eff[7] & enh_reg[ENH_AUTOCTS_BIT] & cts_rise);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tx_cond_reg <= 1'b0;
         thr_reg     <= 1'b0;
         mdl_reg     <= 4'h0;
         flow_reg    <= 1'b0;
         gpi_reg     <= 1'b0;
         xoff_reg    <= 1'b0;
         spc_reg     <= 1'b0;
         rts_reg     <= 1'b0;
      end else begin
         tx_cond_reg <= tx_cond;
         rts_reg     <= RTS_LEVEL;
         thr_reg  <= thr_set | (thr_reg & ~rd_isr & ~wr_thr);
         mdl_reg  <= MODEM_DELTA | (mdl_reg & {4{~rd_msr}});
         flow_reg <= flow_set | (flow_reg & ~rd_msr);
         gpi_reg  <= (|gp_tog) | (gpi_reg & ~rd_gp);
         xoff_reg <= XOFF_MATCH | (xoff_reg & ~XON_MATCH);
         spc_reg  <= SPECIAL_MATCH | (spc_reg & ~rd_isr);
      end
   end

   // -------------------------------------------------------------
   // enabled pending sources and priority encoder
   // -------------------------------------------------------------
   // with enables 3:0 clear the first five sources are off; p_gp has no enable
   wire p_line = ien_eff[2] & (|line_status[4:1] | line_status[7]);
   wire p_tout = ien_eff[0] & fifo_reg & tout_reg;
   wire p_rx   = ien_eff[0] & (fifo_reg ?
                 (RX_STAT.level >= RX_STAT.trig) : dr_reg);
   wire p_tx   = ien_eff[1] & thr_reg;
   wire p_mdm  = ien_eff[3] & (|mdl_reg);
   wire p_gp   = gpi_reg;
   wire p_xoff = ien_eff[5] & (xoff_reg | spc_reg);
   wire p_flow = flow_reg & enh_on;
   wire any_p  = p_line | p_tout | p_rx | p_tx | p_mdm | p_gp |
                 p_xoff | p_flow;
   logic [5:0] code;

   // only the most urgent source is reported; the rest wait
   always_comb begin
      if (p_line)      code = CODE_LINE;
      else if (p_tout) code = CODE_TOUT;
      else if (p_rx)   code = CODE_RECEIVE_READY_EVENT;
      else if (p_tx)   code = CODE_TRANSMIT_READY_EVENT;
      else if (p_mdm)  code = CODE_MODEM;
      else if (p_gp)   code = CODE_GPIO;
      else if (p_xoff) code = CODE_XOFF;
      else if (p_flow) code = CODE_FLOW;
      else             code = CODE_NONE;
   end

   wire [7:0] interrupt_status = {fifo_reg, fifo_reg, code};
   assign IRQ_N = ~any_p;

   // -------------------------------------------------------------
   // read data, captured in the setup cycle
   // -------------------------------------------------------------
   assign rd_mux =
      hit(PADDR, ADDR_DATA)  ? {24'h0, RX_STAT.data} :
      hit(PADDR, ADDR_IEN)   ? {24'h0, ien_reg} :
      hit(PADDR, ADDR_ISTAT) ? {24'h0, interrupt_status} :
      hit(PADDR, ADDR_ENH)   ? {24'h0, enh_reg} :
      hit(PADDR, ADDR_LSTAT) ? {24'h0, line_status} :
      hit(PADDR, ADDR_MSTAT) ? {28'h0, mdl_reg} :
      hit(PADDR, ADDR_GP)    ? {28'h0, pin_reg[3:0]} : 32'h0;

   always_ff @(posedge SYS_CLK) begin
      if (RST)
         prdata_reg <= 32'h0;
      else if (setup_w)
         prdata_reg <= rd_mux;
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_ien1_on;
      wr_ien && PWDATA[1] && !ien_reg[1] && tx_cond;
   endsequence

   AST_IRQ_PIN: assert property (IRQ_N == code[0])
      else $error("irq pin disagrees with status bit 0");
   AST_NONE_CODE: assert property (!any_p |-> interrupt_status[5:0] == 6'h01)
      else $error("idle status code wrong");
   AST_RX_TRIG: assert property (fifo_reg && ien_reg[0] &&
      !p_line && !p_tout && RX_STAT.level >= RX_STAT.trig
      |-> code == 6'h04)
      else $error("receive trigger not reported");
   AST_DR_SET: assert property (RX_STAT.push |=> line_status[0])
      else $error("data ready not set on push");
   AST_TX_IMM: assert property (s_ien1_on |=> p_tx)
      else $error("enable with empty holding gave no interrupt");
   AST_THR_CLR: assert property (wr_thr && !thr_set |=> !thr_reg)
      else $error("transmit ready not cleared by write");
   AST_MSR_CLR: assert property (rd_msr && MODEM_DELTA == 4'h0
      |=> mdl_reg == 4'h0)
      else $error("modem read left delta set");
   AST_LSR_HOLD: assert property (ien_reg[2] && RX_STAT.any_err
      |-> !IRQ_N && code == 6'h06)
      else $error("errored FIFO not signalled");
   AST_OVR: assert property (ien_reg[2] && RX_STAT.overrun
      |=> code == 6'h06)
      else $error("overrun not raised at once");
   AST_TOUT: assert property (tmr_hit && dr_reg && !rd_rhr
      |=> tout_reg)
      else $error("timeout not raised");
   AST_FIFO_BITS: assert property (interrupt_status[7:6] == {2{fifo_reg}})
      else $error("status bits 7:6 wrong");
   AST_SLEEP: assert property (!enh_on |-> !SLEEP_EN)
      else $error("sleep enabled without enhance");
   AST_ACC_PHASE: assert property (PSEL && PENABLE |-> acc_reg == ACC_SETUP)
      else $error("access phase without a setup phase");

endmodule

// ### apb_host_model.sv
/* APB host model: one task per transfer, called by the bench.
   Assumes a slave on sys_clk and a top module named tb. */
`timescale 1ns/1ps

module apb_host_model (
   input  wire logic        sys_clk,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [7:0]  paddr,
   output      logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ------------------------------------------------------------
   // bus transfer
   // ------------------------------------------------------------
   // bus idle from time zero
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end

   // setup, then access held until pready; hang bounded
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      int n;
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 64) begin
         tb.miscompares++;
         tb.stop_test();
      end
   endtask
endmodule

// ### tb.sv
/* Self-checking bench for the UART interrupt prioritiser.
   Assumes the host model drives APB; datapath is stimulus here. */
`timescale 1ns/1ps

module tb;
   import uart_irq_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr, tx_wdata;
   logic [31:0] pwdata, prdata, v;
   logic [6:0]  lvl = 7'h00;
   logic [6:0]  tsp = 7'h00; // free transmit FIFO spaces
   logic [6:0]  ev = 7'h00; // push ovr tick xoff xon spec modem
   logic [2:0]  herr = 3'h0;
   logic        aerr = 1'b0, hold = 1'b0, alle = 1'b0;
   logic        rts = 1'b0, cts_n = 1'b0;
   logic [3:0]  gp = 4'h0;
   logic        rx_pop, tx_wstb, fifo_on, sleep_en, irq_n;
   int          miscompares = 0, cmp_count = 0;

   // ------------------------------------------------------------
   // clock, host and device
   // ------------------------------------------------------------
   always #10 sys_clk = ~sys_clk;

   apb_host_model i_apb_host_model (
      .sys_clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // char length 1 keeps the timeout at sixteen ticks
   uart_irq_core i_uart_irq_core (
      .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr),
      .RX_STAT(rx_stat_t'({lvl, 7'h08, herr, aerr, ev[0], ev[1], 8'h00})),
      .TX_STAT(tx_stat_t'({tsp, 7'h08, hold, alle})),
      .BIT_TICK(ev[2]), .CHAR_BITS(4'h1), .MODEM_DELTA({3'h0, ev[6]}),
      .XOFF_MATCH(ev[3]), .XON_MATCH(ev[4]), .SPECIAL_MATCH(ev[5]),
      .RTS_LEVEL(rts), .CTS_N(cts_n), .GP_IN(gp), .RX_POP(rx_pop),
      .TX_WSTB(tx_wstb), .TX_WDATA(tx_wdata), .FIFO_ON(fifo_on),
      .SLEEP_EN(sleep_en), .IRQ_N(irq_n));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, x);
      cmp_count++;
      if (s !== x) begin
         $display("Error %s expected %h seen %h", n, x, s);
         miscompares++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_apb_host_model.xfer(1'b1, a, d, v, e);
   endtask
   task automatic rd(input logic [7:0] a);
      i_apb_host_model.xfer(1'b0, a, 32'h0, v, e);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk($sformatf("reg %h", a), v, x);
   endtask
   // one-cycle event pulse, seen by the device at the second edge
   task automatic pulse(input int k);
      @(posedge sys_clk);
      ev[k] <= 1'b1;
      @(posedge sys_clk);
      ev[k] <= 1'b0;
   endtask
   // status word with the FIFO bits set
   function automatic logic [31:0] st(input logic [5:0] c);
      return {24'h0, 2'b11, c};
   endfunction
   // irq pin is combinational, so look at it mid-cycle
   task automatic nirq(input logic x);
      @(negedge sys_clk);
      chk("irq_n", {31'h0, irq_n}, {31'h0, x});
   endtask
   task automatic stop_test;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rc(ADDR_IEN, {24'h0, IEN_RESET});
      rc(ADDR_ISTAT, 32'h01);
      nirq(1'b1);
      rc(8'h30, 32'h0);
      chk("pslverr", {31'h0, e}, 32'h1);
   endtask
   task automatic t_rx;
      wr(ADDR_ISTAT, 32'h01);
      wr(ADDR_IEN, 32'h01);
      @(posedge sys_clk);
      lvl <= 7'h07;
      pulse(0);
      rc(ADDR_LSTAT, 32'h01);
      rc(ADDR_ISTAT, st(CODE_NONE));
      @(posedge sys_clk);
      lvl <= 7'h08;
      rc(ADDR_ISTAT, st(CODE_RECEIVE_READY_EVENT));
      nirq(1'b0);
      chk("fifo_on", {31'h0, fifo_on}, 32'h1);
      @(posedge sys_clk);
      lvl <= 7'h07;
      rc(ADDR_ISTAT, st(CODE_NONE));
      @(posedge sys_clk);
      lvl <= 7'h00;
      rc(ADDR_LSTAT, 32'h00);
   endtask
   task automatic t_poll;
      wr(ADDR_IEN, 32'h00);
      @(posedge sys_clk);
      lvl <= 7'h08;
      pulse(0);
      rc(ADDR_ISTAT, st(CODE_NONE));
      rc(ADDR_LSTAT, 32'h01);
      nirq(1'b1);
   endtask
   task automatic t_tx;
      // FIFO mode: one free space above the transmit trigger
      @(posedge sys_clk);
      {hold, tsp} <= {1'b1, 7'h09};
      wr(ADDR_IEN, 32'h02);
      rc(ADDR_ISTAT, st(CODE_TRANSMIT_READY_EVENT));
      rc(ADDR_ISTAT, st(CODE_NONE));
      wr(ADDR_IEN, 32'h00);
      wr(ADDR_IEN, 32'h02);
      cyc(1);
      nirq(1'b0);
      wr(ADDR_DATA, 32'h5a);
      @(negedge sys_clk);
      chk("tx_wstb", {31'h0, tx_wstb}, 32'h1);
      rc(ADDR_ISTAT, st(CODE_NONE));
      chk("tx_wdata", {24'h0, tx_wdata}, 32'h5a);
   endtask
   task automatic t_line;
      @(posedge sys_clk);
      {lvl, aerr, herr, alle} <= {7'h08, 1'b1, 3'h5, 1'b1};
      wr(ADDR_IEN, 32'h07);
      rc(ADDR_ISTAT, st(CODE_LINE));
      rc(ADDR_LSTAT, 32'hf5);
      rc(ADDR_ISTAT, st(CODE_LINE));
      @(posedge sys_clk);
      {aerr, herr} <= 4'h0;
      rc(ADDR_ISTAT, st(CODE_RECEIVE_READY_EVENT));
      pulse(1);
      rc(ADDR_ISTAT, st(CODE_LINE));
      rc(ADDR_LSTAT, 32'h63);
      rc(ADDR_ISTAT, st(CODE_RECEIVE_READY_EVENT));
   endtask
   task automatic t_modem_gp;
      wr(ADDR_IEN, 32'h08);
      @(posedge sys_clk);
      lvl <= 7'h00;
      pulse(6);
      rc(ADDR_ISTAT, st(CODE_MODEM));
      rd(ADDR_MSTAT);
      chk("modem delta", {28'h0, v[3:0]}, 32'h1);
      rc(ADDR_ISTAT, st(CODE_NONE));
      @(posedge sys_clk);
      gp <= 4'h2;
      cyc(6);
      rc(ADDR_ISTAT, st(CODE_GPIO));
      rc(ADDR_GP, 32'h02);
      rc(ADDR_ISTAT, st(CODE_NONE));
   endtask
   task automatic t_enh;
      wr(ADDR_IEN, 32'hf0);
      pulse(3);
      rc(ADDR_ISTAT, st(CODE_NONE));
      chk("sleep_en", {31'h0, sleep_en}, 32'h0);
      pulse(4);
      wr(ADDR_ENH, 32'hd0);
      pulse(3);
      rc(ADDR_ISTAT, st(CODE_XOFF));
      chk("sleep_en", {31'h0, sleep_en}, 32'h1);
      rc(ADDR_ISTAT, st(CODE_XOFF));
      pulse(4);
      rc(ADDR_ISTAT, st(CODE_NONE));
      pulse(5);
      rc(ADDR_ISTAT, st(CODE_XOFF));
      rc(ADDR_ISTAT, st(CODE_NONE));
      @(posedge sys_clk);
      rts <= 1'b1;
      cyc(2);
      rc(ADDR_ISTAT, st(CODE_FLOW));
      rd(ADDR_MSTAT);
      rc(ADDR_ISTAT, st(CODE_NONE));
      @(posedge sys_clk);
      cts_n <= 1'b1;
      cyc(6);
      rc(ADDR_ISTAT, st(CODE_FLOW));
      rd(ADDR_MSTAT);
      rc(ADDR_ISTAT, st(CODE_NONE));
      wr(ADDR_ENH, 32'h00);
   endtask
   task automatic t_tout;
      wr(ADDR_IEN, 32'h01);
      @(posedge sys_clk);
      lvl <= 7'h01;
      pulse(0);
      repeat (15) pulse(2);
      rc(ADDR_ISTAT, st(CODE_NONE));
      pulse(2);
      rc(ADDR_ISTAT, st(CODE_TOUT));
      rd(ADDR_DATA);
      @(negedge sys_clk);
      chk("rx_pop", {31'h0, rx_pop}, 32'h1);
      rc(ADDR_ISTAT, st(CODE_NONE));
      wr(ADDR_ISTAT, 32'h00);
      rc(ADDR_ISTAT, 32'h04);
      nirq(1'b0);
      chk("fifo_on", {31'h0, fifo_on}, 32'h0);
   endtask

   // reset for eight cycles, then the scenarios in order
   initial begin
      cyc(8);
      rst <= 1'b0;
      cyc(2);
      t_reset();
      t_rx();
      t_poll();
      t_tx();
      t_line();
      t_modem_gp();
      t_enh();
      t_tout();
      stop_test();
   end
endmodule
